//--- rtl/pwm_consts.svh
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// register byte offsets
`define ADDR_CTRL       12'h000
`define ADDR_RELOAD     12'h004
`define ADDR_DUTY0      12'h008
`define ADDR_DUTY1      12'h00C
`define ADDR_DUTY2      12'h010
`define ADDR_DUTY3      12'h014
`define ADDR_STATUS     12'h018
`define ADDR_COUNT      12'h01C

// control register fields
`define CTRL_RUN_BIT    0
`define CTRL_EN_LSB     4
`define CTRL_POL_LSB    8
`define CTRL_DIV_LSB    16
`define CTRL_DIV_W      8

// reset values and counter maximum
`define RST_CTRL        32'h0000_0000
`define RST_RELOAD      12'h000
`define RST_DUTY        12'h000
`define CNT_MAX         12'hFFF

`endif

//--- rtl/pwm_pkg.sv
package pwm_pkg;
    typedef logic [11:0] count_type;
    typedef enum logic [0:0] {
        POL_ZERO = 1'b0,
        POL_ONE  = 1'b1
    } polarity_type;
endpackage

//--- rtl/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tick_divider
    import pwm_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         I_CLK,     // system clock
    input  wire logic         I_SYS_RST, // sync reset
    input  wire logic         i_run,     // divider enable
    input  wire logic [W-1:0] i_div,     // divide by i_div+1
    output logic              o_tick     // one-cycle tick
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_tick;

    always_comb begin
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (i_run) begin
            if (cnt >= i_div) begin
                next_cnt  = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end else begin
            next_cnt = '0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

//--- rtl/pwm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
    import pwm_pkg::*;
(
    input  wire logic         I_CLK,     // system clock
    input  wire logic         I_SYS_RST, // sync reset
    input  wire logic         i_en,      // channel enable
    input  wire polarity_type i_pol,     // polarity setting
    input  wire count_type    i_count,   // shared counter
    input  wire count_type    i_duty,    // duty value
    output logic              o_pwm      // registered output
);
    logic next_pwm;
    logic above;

    always_comb begin
        above    = i_count > i_duty;
        next_pwm = 1'b0;
        if (i_en) begin
            if (i_pol == POL_ZERO) begin
                next_pwm = ~above; // [R3]
            end else begin
                next_pwm = above;  // [R4]
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            o_pwm <= 1'b0;
        end else begin
            o_pwm <= next_pwm;
        end
    end
endmodule
`default_nettype wire

//--- rtl/auto_reload_pwm_channels.sv
// Overview of operation
// R1: four channels 0..3, each with its own enable, duty value and polarity.
// R2: a 12-bit reload value accepts any setting 0x000..0xFFF.
// R3: polarity zero drives low when count exceeds duty, else high.
// R4: polarity one drives high when count exceeds duty, else low.
// R5: each channel has a 12-bit duty register loadable 0x000..0xFFF.
// R6: software sets duty above reload to get a toggling output.
// R7: software sets up the counter clock before configuring channels.
// R8: counter counts up per tick and reloads from the reload value at 0xFFF.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_consts.svh"
module auto_reload_pwm_channels
    import pwm_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input  wire logic        I_CLK,     // 10 MHz clock
    input  wire logic        I_SYS_RST, // sync reset, active high
    input  wire logic        PSEL,      // apb select
    input  wire logic        PENABLE,   // apb enable
    input  wire logic        PWRITE,    // apb direction
    input  wire logic [11:0] PADDR,     // apb byte address
    input  wire logic [31:0] PWDATA,    // apb write data
    output logic      [31:0] PRDATA,    // apb read data
    output logic             PREADY,    // apb ready
    output logic             PSLVERR,   // apb error
    output logic [NUM_CH-1:0] O_PWM     // channel output pins
);
    logic [31:0]     ctrl;
    logic [31:0]     next_ctrl;
    count_type       reload_value_register;
    count_type       next_reload;
    count_type       duty [NUM_CH];
    count_type       next_duty [NUM_CH];
    count_type       count;
    count_type       next_count;
    logic            wrap_seen;
    logic            next_wrap_seen;
    logic            tick;
    logic            access;
    logic            run;

    function automatic logic addr_valid(input logic [11:0] a);
        addr_valid = (a == `ADDR_CTRL)   || (a == `ADDR_RELOAD) ||
                     (a == `ADDR_DUTY0)  || (a == `ADDR_DUTY1)  ||
                     (a == `ADDR_DUTY2)  || (a == `ADDR_DUTY3)  ||
                     (a == `ADDR_STATUS) || (a == `ADDR_COUNT);
    endfunction

    function automatic int duty_index(input logic [11:0] a);
        duty_index = (int'(a) - int'(`ADDR_DUTY0)) / 4;
    endfunction

    assign access = PSEL && PENABLE;
    assign run    = ctrl[`CTRL_RUN_BIT];
    // zero wait states: answer in the access phase itself
    assign PREADY = 1'b1;

    // counter clock setup: run bit plus prescaler
    tick_divider #(
        .W(`CTRL_DIV_W)
    ) u_div (
        .I_CLK    (I_CLK),
        .I_SYS_RST(I_SYS_RST),
        .i_run    (run),
        .i_div    (ctrl[`CTRL_DIV_LSB +: `CTRL_DIV_W]),
        .o_tick   (tick)
    );

    always_comb begin
        next_ctrl   = ctrl;
        next_reload = reload_value_register;
        for (int i = 0; i < NUM_CH; i++) begin
            next_duty[i] = duty[i];
        end
        if (access) begin
            if (PWRITE) begin
                case (PADDR)
                    `ADDR_CTRL: next_ctrl = PWDATA & 32'h00FF_0FF1;
                    `ADDR_RELOAD: next_reload = PWDATA[11:0]; // [R2]
                    `ADDR_DUTY0, `ADDR_DUTY1, `ADDR_DUTY2, `ADDR_DUTY3:
                        next_duty[duty_index(PADDR)] = PWDATA[11:0]; // [R5]
                    default: ;
                endcase
            end
        end
    end

    // read data mux is combinational so data is valid in the access phase
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (access && !PWRITE) begin
            case (PADDR)
                `ADDR_CTRL:   PRDATA = ctrl;
                `ADDR_RELOAD: PRDATA = {20'h00000, reload_value_register};
                `ADDR_DUTY0, `ADDR_DUTY1, `ADDR_DUTY2, `ADDR_DUTY3:
                    PRDATA = {20'h00000, duty[duty_index(PADDR)]};
                `ADDR_STATUS: PRDATA = {27'h0000000, wrap_seen,
                                        O_PWM[3:0]};
                `ADDR_COUNT:  PRDATA = {20'h00000, count};
                default:      PRDATA = 32'h0000_0000;
            endcase
        end
    end

    assign PSLVERR = access && !addr_valid(PADDR);

    always_comb begin
        next_count     = count;
        next_wrap_seen = wrap_seen;
        if (!run) begin
            // stopped counter restarts from the reload value
            next_count = reload_value_register;
        end else if (tick) begin
            if (count == `CNT_MAX) begin
                next_count     = reload_value_register; // [R8]
                next_wrap_seen = 1'b1;
            end else begin
                next_count = count + 12'h001; // [R8]
            end
        end
        // status read clears the wrap flag; a wrap in the same cycle wins
        if (access && !PWRITE && PADDR == `ADDR_STATUS &&
            !(run && tick && count == `CNT_MAX)) begin
            next_wrap_seen = 1'b0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            ctrl                  <= `RST_CTRL;
            reload_value_register <= `RST_RELOAD;
            for (int i = 0; i < NUM_CH; i++) begin
                duty[i] <= `RST_DUTY;
            end
            count     <= `RST_RELOAD;
            wrap_seen <= 1'b0;
        end else begin
            ctrl                  <= next_ctrl;
            reload_value_register <= next_reload;
            for (int i = 0; i < NUM_CH; i++) begin
                duty[i] <= next_duty[i];
            end
            count     <= next_count;
            wrap_seen <= next_wrap_seen;
        end
    end

    // output with duty < reload never toggles; software must obey [R6]
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        pwm_channel u_ch (
            .I_CLK    (I_CLK),
            .I_SYS_RST(I_SYS_RST),
            .i_en     (ctrl[`CTRL_EN_LSB + g]),         // [R1]
            .i_pol    (polarity_type'(ctrl[`CTRL_POL_LSB + g])),
            .i_count  (count),
            .i_duty   (duty[g]),
            .o_pwm    (O_PWM[g])
        );
    end
endmodule
`default_nettype wire

//--- sim/pwm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_checker
#(
    parameter int NUM_CH = 4
) (
    input wire logic              I_CLK,     // clock
    input wire logic              I_SYS_RST, // sync reset
    input wire logic              PSEL,      // apb select
    input wire logic              PENABLE,   // apb enable
    input wire logic              PWRITE,    // apb direction
    input wire logic [11:0]       PADDR,     // apb address
    input wire logic [31:0]       PWDATA,    // apb write data
    input wire logic [31:0]       PRDATA,    // apb read data
    input wire logic              PREADY,    // apb ready
    input wire logic              PSLVERR,   // apb error
    input wire logic [NUM_CH-1:0] O_PWM      // outputs
);
    logic [11:0] shadow [1:5];
    logic [3:0]  en;
    wire acc = PSEL && PENABLE;
    wire mapped = (PADDR <= 12'h01C) && (PADDR[1:0] == 2'h0);
    wire rng = mapped && (PADDR >= 12'h004) && (PADDR <= 12'h014);
    // shadow of what software wrote, to judge read-back
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            shadow <= '{default: 12'h000};
            en <= 4'h0;
        end else if (acc && PWRITE) begin
            if (rng) shadow[PADDR[4:2]] <= PWDATA[11:0];
            if (PADDR == 12'h000) en <= PWDATA[7:4];
        end
    end
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_reload_readback: assert property (acc && !PWRITE && PADDR == 12'h004
        |-> PRDATA == {20'h0, shadow[1]}) else $error("reload read-back");
    a_duty_readback: assert property (acc && !PWRITE && rng
        |-> PRDATA == {20'h0, shadow[PADDR[4:2]]}) else $error("duty read-back");
    a_disabled_low: assert property ((O_PWM & ~en & ~$past(en)) == 4'h0)
        else $error("disabled channel drives high");
    a_reset_outputs: assert property (@(posedge I_CLK) disable iff (1'b0)
        I_SYS_RST |=> O_PWM == 4'h0) else $error("output high after reset");
    a_err_unmapped: assert property (acc && !mapped |-> PSLVERR
        && PRDATA == 32'h0) else $error("unmapped access not refused");
    a_no_err: assert property (acc && mapped |-> !PSLVERR)
        else $error("error on mapped access");
    a_ready_zero: assert property (acc |-> PREADY)
        else $error("ready missing in access");
    a_status_mirror: assert property (acc && !PWRITE && PADDR == 12'h018
        |-> PRDATA[3:0] == O_PWM) else $error("status differs from outputs");
    c_ctrl_write: cover property (acc && PWRITE && PADDR == 12'h000);
    c_toggle: cover property (O_PWM[0] ##1 !O_PWM[0]);
    c_unmapped: cover property (acc && !mapped);
endmodule
bind auto_reload_pwm_channels pwm_checker #(.NUM_CH(NUM_CH)) u_pwm_checker (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .O_PWM(O_PWM));
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic        rdy;
    logic        err;
    logic [3:0]  pwm;
    logic [31:0] rd;
    logic        re;
    int          fails = 0;
    int          num_checks = 0;
    always #50 clk = ~clk;
    auto_reload_pwm_channels u_auto_reload_pwm_channels (.I_CLK(clk),
        .I_SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .O_PWM(pwm));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        re = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 6; i++) rdchk(12'(4*i), 32'h0);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        rdchk(12'h004, 32'h0000_0FFF);
        for (int i = 2; i < 6; i++) apb(1'b1, 12'(4*i), 32'(12'hA50 + i));
        for (int i = 2; i < 6; i++) rdchk(12'(4*i), 32'(12'hA50 + i));
        apb(1'b1, 12'h020, 32'h1);
        chk({31'h0, re}, 32'h1);
        rdchk(12'h020, 32'h0);
    endtask
    task automatic t_pol;
        // counter stopped holds the reload value: exact compare boundary
        apb(1'b1, 12'h004, 32'h800);
        for (int i = 0; i < 4; i++)
            apb(1'b1, 12'(8+4*i), (i % 2) ? 32'h7FF : 32'h800);
        apb(1'b1, 12'h000, 32'h0000_0CF0);
        repeat (4) @(posedge clk);
        chk({28'h0, pwm}, 32'h9);
        rdchk(12'h018, 32'h9);
        apb(1'b1, 12'h000, 32'h0000_03F0);
        repeat (4) @(posedge clk);
        chk({28'h0, pwm}, 32'h6);
        rdchk(12'h01C, 32'h800);
        apb(1'b1, 12'h000, 32'h0000_0300);
        repeat (4) @(posedge clk);
        chk({28'h0, pwm}, 32'h0);
    endtask
    task automatic t_wrap;
        logic [3:0] seen;
        logic [1:0] lvl;
        seen = 4'h0;
        lvl = 2'h0;
        // period of four against three-cycle reads visits every phase
        apb(1'b1, 12'h004, 32'hFFC);
        apb(1'b1, 12'h008, 32'hFFD);
        apb(1'b1, 12'h000, 32'h0000_0011);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, 12'h01C, 32'h0);
            chk({31'h0, rd[11:0] >= 12'hFFC}, 32'h1);
            seen[rd[1:0]] = 1'b1;
            lvl[pwm[0]] = 1'b1;
        end
        chk({28'h0, seen}, 32'hF);
        chk({30'h0, lvl}, 32'h3);
        // stopping holds the count at the reload value, so the sticky wrap flag reads once
        apb(1'b1, 12'h000, 32'h0000_0010);
        rdchk(12'h018, 32'h11);
        rdchk(12'h018, 32'h01);
        // slowest prescaler: no tick within the next few reads
        apb(1'b1, 12'h000, 32'h00FF_0011);
        rdchk(12'h01C, 32'hFFC);
        rdchk(12'h01C, 32'hFFC);
    endtask
    task automatic conclude;
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_pol;
        t_wrap;
        conclude;
    end
    initial begin
        #500000;
        fails++;
        conclude;
    end
endmodule
`default_nettype wire
